// ### design/udbl_top.v
// dma burst/chain configuration, rx burst engine and buffer descriptor table
//
// Function
// [RULE_01] The source burst field codes 000..110 as 1, 4, 8, 16, 32, 64 and 128 transfers.
// [RULE_02] A final burst shorter than the programmed one carries only the remaining items.
// [RULE_03] Software keeps the source burst no larger than the rx endpoint max packet size.
// [RULE_04] Software writes the same burst value into the system dma channel control register.
// [RULE_05] The reserved bit between the two burst fields always reads zero.
// [RULE_06] The upper byte of the chain register holds the rx descriptor chain length.
// [RULE_07] The lower byte of the chain register holds the tx descriptor chain length.
// [RULE_08] Software never writes a zero chain length while that channel is linked.
// [RULE_09] With linking off a channel ignores its chain length field.
// [RULE_10] Packet memory is reached over ahb only at 16-bit aligned addresses.
// [RULE_11] The buffer address entry of endpoint n sits at table base plus eight times n.
// [RULE_12] The upper half of the entry points at the buffer for the next out or setup data.
// [RULE_13] The lower half of the entry points at the buffer sent on the next in token.
// [RULE_14] Software writes zero into the two low bits of both buffer pointers.
// [RULE_15] Packet memory starts at a fixed system address and table addresses are relative to it.
// [RULE_16] The source burst field is the three lowest bits of the burst size register.
`timescale 1ns/10ps
`include "udbl_defs.vh"

// ---------------------------------------------------------------
// synchronous fifo
// ---------------------------------------------------------------
module udbl_fifo
#(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output reg  [AW:0]      count
);

  reg  [WIDTH-1:0] store [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  wire             push;
  wire             pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = store[rd_ptr];

  always @(posedge clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end

endmodule

// ---------------------------------------------------------------
// top
// ---------------------------------------------------------------
module udbl_top
#(
  parameter PM_WORDS = 256,
  parameter PM_AW    = 8,
  parameter EP_W     = 4,
  parameter FIFO_D   = 8,
  parameter FIFO_AW  = 3
)
(
  input  wire            CLK,
  input  wire            SYS_RST,
  // ahb slave
  input  wire            HSEL,
  input  wire [31:0]     HADDR,
  input  wire [1:0]      HTRANS,
  input  wire            HWRITE,
  input  wire [2:0]      HSIZE,
  input  wire [31:0]     HWDATA,
  input  wire            HREADY,
  output reg  [31:0]     HRDATA,
  output reg             HREADYOUT,
  output reg             HRESP,
  // endpoint side: descriptor table lookup
  input  wire [EP_W-1:0] EP_INDEX,
  output reg  [15:0]     RX_BUF_POINTER,
  output reg  [15:0]     TX_BUF_POINTER,
  // linked-list control
  input  wire            RX_LINKING_ON,
  input  wire            TX_LINKING_ON,
  input  wire            RX_CHAIN_START,
  input  wire            TX_CHAIN_START,
  input  wire            RX_DESC_DONE,
  input  wire            TX_DESC_DONE,
  output wire [7:0]      RX_CHAIN_LEFT,
  output wire [7:0]      TX_CHAIN_LEFT,
  output wire            RX_CHAIN_END,
  output wire            TX_CHAIN_END,
  // rx data stream from the serial engine
  input  wire            RX_XFER_LOAD,
  input  wire [15:0]     RX_XFER_COUNT,
  input  wire            RX_DATA_VALID,
  output wire            RX_DATA_READY,
  input  wire [31:0]     RX_DATA,
  // rx stream toward the system dma
  output reg             DMA_BURST_REQ,
  output reg  [7:0]      DMA_BURST_LEN,
  output reg             DMA_LAST_BURST,
  output wire            DMA_VALID,
  input  wire            DMA_READY,
  output wire [31:0]     DMA_DATA
);

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  reg  [15:0]        burst_size;
  reg  [15:0]        chain_len;
  reg  [15:0]        table_base;
  reg  [31:0]        pmem [0:PM_WORDS-1];

  reg                dp_wr;
  reg                dp_rd;
  reg  [31:0]        dp_addr;
  reg  [2:0]         dp_size;

  reg  [15:0]        xfer_left;
  reg  [7:0]         burst_left;
  reg                bursting;

  wire               accept;
  wire               in_regs;
  wire               in_pmem;
  wire               aligned;
  wire [11:0]        reg_ofs;
  wire [PM_AW-1:0]   pm_idx;
  reg  [3:0]         lanes;
  reg  [31:0]        rd_value;
  wire [31:0]        pm_wdata;

  wire [FIFO_AW:0]   fifo_count;
  wire               fifo_valid;
  wire [7:0]         sb_words;
  wire [7:0]         eff_len;
  wire [7:0]         need;
  wire [PM_AW-1:0]   entry_idx;

  // ---------------------------------------------------------------
  // ahb address decode
  // ---------------------------------------------------------------
  assign accept  = HSEL & HTRANS[1] & HREADY;
  assign in_regs = (dp_addr - `UDBL_REG_BASE) < `UDBL_REG_SPAN;
  assign in_pmem = (dp_addr - `UDBL_PMEM_BASE) < `UDBL_PMEM_SPAN;                  // [RULE_15]
  assign reg_ofs = dp_addr[11:0];
  // odd byte addresses and misaligned words are dropped, reads return zero
  assign aligned = ~dp_addr[0] & ~(dp_size[1] & dp_addr[1]);                        // [RULE_10]
  assign pm_idx  = dp_addr[PM_AW+1:2];

  always @*
  begin
    lanes = 4'h0;
    case (dp_size)
      3'h0:    lanes = 4'h1 << dp_addr[1:0];
      3'h1:    lanes = dp_addr[1] ? 4'hc : 4'h3;
      3'h2:    lanes = 4'hf;
      default: lanes = 4'h0;
    endcase
  end

  always @*
  begin
    rd_value = 32'h0000_0000;
    if (aligned & in_pmem)
      rd_value = pmem[pm_idx];
    else if (aligned & in_regs & ~dp_addr[1])
    begin
      case (reg_ofs)
        `UDBL_OFS_BURST_SIZE: rd_value = {16'h0000, burst_size & `UDBL_BS_WMASK}; // [RULE_05]
        `UDBL_OFS_CHAIN_LEN:  rd_value = {16'h0000, chain_len};
        `UDBL_OFS_TABLE_BASE: rd_value = {16'h0000, table_base};
        default:              rd_value = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // ahb slave: zero-wait writes, one wait state on reads
  // ---------------------------------------------------------------
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      dp_wr     <= 1'b0;
      dp_rd     <= 1'b0;
      dp_addr   <= 32'h0000_0000;
      dp_size   <= 3'h0;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      dp_wr <= 1'b0;
      if (dp_rd)
      begin
        HRDATA    <= rd_value;
        HREADYOUT <= 1'b1;
        dp_rd     <= 1'b0;
      end
      else if (accept)
      begin
        dp_addr <= HADDR;
        dp_size <= HSIZE;
        dp_wr   <= HWRITE;
        if (~HWRITE)
        begin
          dp_rd     <= 1'b1;
          HREADYOUT <= 1'b0;
        end
      end
    end
  end

  // packet memory writes in the write data phase; one writer keeps the array single-driven
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_lane
      assign pm_wdata[8*b+7:8*b] = lanes[b] ? HWDATA[8*b+7:8*b] : pmem[pm_idx][8*b+7:8*b];
    end
  endgenerate

  always @(posedge CLK)
  begin
    if (dp_wr & aligned & in_pmem)
      pmem[pm_idx] <= pm_wdata;                                                   // [RULE_10]
  end

  // configuration registers; upper halfword writes fall on no register
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      burst_size <= `UDBL_RST_BURST_SIZE;
      chain_len  <= `UDBL_RST_CHAIN_LEN;
      table_base <= `UDBL_RST_TABLE_BASE;
    end
    else if (dp_wr & aligned & in_regs & ~dp_addr[1])
    begin
      case (reg_ofs)
        `UDBL_OFS_BURST_SIZE:
        begin
          if (lanes[0])
            burst_size[7:0] <= {1'b0, HWDATA[6:4], 1'b0, HWDATA[2:0]};           // [RULE_05]
          if (lanes[1])
            burst_size[15:8] <= HWDATA[15:8];
        end
        `UDBL_OFS_CHAIN_LEN:
        begin
          if (lanes[0])
            chain_len[`UDBL_CL_TX_HI:`UDBL_CL_TX_LO] <= HWDATA[7:0];              // [RULE_07]
          if (lanes[1])
            chain_len[`UDBL_CL_RX_HI:`UDBL_CL_RX_LO] <= HWDATA[15:8];             // [RULE_06]
        end
        `UDBL_OFS_TABLE_BASE:
        begin
          if (lanes[0])
            table_base[7:0] <= {HWDATA[7:3], 3'b000};
          if (lanes[1])
            table_base[15:8] <= HWDATA[15:8];
        end
        default:
        begin
          table_base <= table_base;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // descriptor table lookup
  // ---------------------------------------------------------------
  // entry word = (base + 8n) / 4, relative to packet memory start
  assign entry_idx = table_base[PM_AW+1:2]
                   + {{(PM_AW-EP_W-1){1'b0}}, EP_INDEX, 1'b0};                      // [RULE_11]

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RX_BUF_POINTER <= 16'h0000;
      TX_BUF_POINTER <= 16'h0000;
    end
    else
    begin
      // low two bits of each half are not used; the pointers always get 2'b00 there
      RX_BUF_POINTER <= {pmem[entry_idx][`UDBL_ADR_RX_HI:`UDBL_ADR_RX_LO], 2'b00}; // [RULE_12]
      TX_BUF_POINTER <= {pmem[entry_idx][`UDBL_ADR_TX_HI:`UDBL_ADR_TX_LO], 2'b00}; // [RULE_13]
    end
  end

  // ---------------------------------------------------------------
  // linked-list descriptor countdown, rx channel 1, tx channel 0
  // ---------------------------------------------------------------
  wire [1:0]  link_on;
  wire [1:0]  ch_start;
  wire [1:0]  ch_done;
  wire [15:0] desc_left;
  wire [1:0]  ch_end;

  assign link_on  = {RX_LINKING_ON, TX_LINKING_ON};
  assign ch_start = {RX_CHAIN_START, TX_CHAIN_START};
  assign ch_done  = {RX_DESC_DONE, TX_DESC_DONE};

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_chan
      reg [7:0] left;
      reg       fin;

      assign desc_left[8*c+7:8*c] = left;
      assign ch_end[c]            = fin;

      always @(posedge CLK or posedge SYS_RST)
      begin
        if (SYS_RST)
        begin
          left <= 8'h00;
          fin  <= 1'b0;
        end
        else if (~link_on[c])
        begin
          // unlinked: chain length has no effect at all
          left <= 8'h00;                                                          // [RULE_09]
          fin  <= 1'b0;
        end
        else if (ch_start[c])
        begin
          left <= chain_len[8*c+7:8*c];                                           // [RULE_06] [RULE_07]
          fin  <= 1'b0;
        end
        else if (ch_done[c] && left != 8'h00)
        begin
          left <= left - 8'h01;
          fin  <= (left == 8'h01);
        end
      end
    end
  endgenerate

  assign RX_CHAIN_LEFT = desc_left[15:8];
  assign TX_CHAIN_LEFT = desc_left[7:0];
  assign RX_CHAIN_END  = ch_end[1];
  assign TX_CHAIN_END  = ch_end[0];

  // ---------------------------------------------------------------
  // rx burst engine
  // ---------------------------------------------------------------
  function [7:0] udbl_burst_words;
    input [2:0] code;
    begin
      case (code)
        `UDBL_SB_1:   udbl_burst_words = 8'h01;
        `UDBL_SB_4:   udbl_burst_words = 8'h04;
        `UDBL_SB_8:   udbl_burst_words = 8'h08;
        `UDBL_SB_16:  udbl_burst_words = 8'h10;
        `UDBL_SB_32:  udbl_burst_words = 8'h20;
        `UDBL_SB_64:  udbl_burst_words = 8'h40;
        `UDBL_SB_128: udbl_burst_words = 8'h80;
        default:      udbl_burst_words = 8'h01;
      endcase
    end
  endfunction

  assign sb_words = udbl_burst_words(burst_size[`UDBL_BS_SBURST_HI:`UDBL_BS_SBURST_LO]); // [RULE_01] [RULE_16]
  assign eff_len  = (xfer_left < {8'h00, sb_words}) ? xfer_left[7:0] : sb_words;       // [RULE_02]
  // the fifo only holds a few words, so long bursts start once it is full
  assign need     = (eff_len > FIFO_D[7:0]) ? FIFO_D[7:0] : eff_len;

  udbl_fifo
  #(
    .WIDTH (32),
    .DEPTH (FIFO_D),
    .AW    (FIFO_AW)
  )
  u_fifo
  (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_valid  (RX_DATA_VALID),
    .in_ready  (RX_DATA_READY),
    .in_data   (RX_DATA),
    .out_valid (fifo_valid),
    .out_ready (bursting & DMA_READY),
    .out_data  (DMA_DATA),
    .count     (fifo_count)
  );

  assign DMA_VALID = bursting & fifo_valid;

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      xfer_left      <= 16'h0000;
      burst_left     <= 8'h00;
      bursting       <= 1'b0;
      DMA_BURST_REQ  <= 1'b0;
      DMA_BURST_LEN  <= 8'h00;
      DMA_LAST_BURST <= 1'b0;
    end
    else if (RX_XFER_LOAD & ~bursting)
    begin
      xfer_left <= RX_XFER_COUNT;
    end
    else if (~bursting)
    begin
      if (xfer_left != 16'h0000 && {{(7-FIFO_AW){1'b0}}, fifo_count} >= need)
      begin
        bursting       <= 1'b1;
        burst_left     <= eff_len;
        DMA_BURST_REQ  <= 1'b1;
        DMA_BURST_LEN  <= eff_len;                                                 // [RULE_02]
        DMA_LAST_BURST <= (xfer_left == {8'h00, eff_len});
      end
    end
    else if (DMA_READY & fifo_valid)
    begin
      xfer_left  <= xfer_left - 16'h0001;
      burst_left <= burst_left - 8'h01;
      if (burst_left == 8'h01)
      begin
        bursting       <= 1'b0;
        DMA_BURST_REQ  <= 1'b0;
        DMA_LAST_BURST <= 1'b0;
      end
    end
  end

endmodule

// ### design/udbl_defs.vh
// register offsets, field positions, reset values and memory layout for the dma/buffer-table block
`ifndef UDBL_DEFS_VH
`define UDBL_DEFS_VH

// ---------------------------------------------------------------
// register block
// ---------------------------------------------------------------
`define UDBL_REG_BASE        32'hc000_9000
`define UDBL_REG_SPAN        32'h0000_1000
`define UDBL_OFS_TABLE_BASE  12'h850
`define UDBL_OFS_BURST_SIZE  12'h860
`define UDBL_OFS_CHAIN_LEN   12'h864

`define UDBL_RST_BURST_SIZE  16'h0100
`define UDBL_RST_CHAIN_LEN   16'h0000
`define UDBL_RST_TABLE_BASE  16'h0000

// burst size register fields
`define UDBL_BS_NPKT_HI      15
`define UDBL_BS_NPKT_LO      8
`define UDBL_BS_DBURST_HI    6
`define UDBL_BS_DBURST_LO    4
`define UDBL_BS_RSVD_BIT     3
`define UDBL_BS_SBURST_HI    2
`define UDBL_BS_SBURST_LO    0
`define UDBL_BS_WMASK        16'hff77

// chain length register fields
`define UDBL_CL_RX_HI        15
`define UDBL_CL_RX_LO        8
`define UDBL_CL_TX_HI        7
`define UDBL_CL_TX_LO        0

// descriptor table base: 8-byte aligned entries
`define UDBL_TB_WMASK        16'hfff8

// buffer address entry fields
`define UDBL_ADR_RX_HI       31
`define UDBL_ADR_RX_LO       18
`define UDBL_ADR_TX_HI       15
`define UDBL_ADR_TX_LO       2
`define UDBL_ENTRY_STRIDE    8

// packet memory
`define UDBL_PMEM_BASE       32'hc000_8800
`define UDBL_PMEM_SPAN       32'h0000_0400

// source burst encodings
`define UDBL_SB_1            3'h0
`define UDBL_SB_4            3'h1
`define UDBL_SB_8            3'h2
`define UDBL_SB_16           3'h3
`define UDBL_SB_32           3'h4
`define UDBL_SB_64           3'h5
`define UDBL_SB_128          3'h6

`endif

// ### testbench/udbl_top_assertions.sv
// concurrent checks on the ports of the dma/buffer-table block
`timescale 1ns/10ps
`include "udbl_defs.vh"

module udbl_top_assertions (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        RX_LINKING_ON,
  input wire logic        TX_LINKING_ON,
  input wire logic        RX_CHAIN_START,
  input wire logic        TX_CHAIN_START,
  input wire logic        RX_DESC_DONE,
  input wire logic        TX_DESC_DONE,
  input wire logic [7:0]  RX_CHAIN_LEFT,
  input wire logic [7:0]  TX_CHAIN_LEFT,
  input wire logic        TX_CHAIN_END,
  input wire logic        DMA_VALID,
  input wire logic        DMA_BURST_REQ,
  input wire logic [7:0]  DMA_BURST_LEN
);
  localparam logic [31:0] BS_ADDR = `UDBL_REG_BASE + 32'h860;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  // ---------------------------------------------------------------
  // bus reads and error response
  // ---------------------------------------------------------------
  sequence rd_req;
    HSEL && HTRANS[1] && HREADY && !HWRITE;
  endsequence
  sequence rd_answer;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  a_read_wait_state: assert property (rd_req |=> rd_answer)
    else $error("read did not take one wait state");
  a_odd_read_zero: assert property (rd_req ##0 HADDR[0] |=> rd_answer ##0 (HRDATA == 32'h0))
    else $error("odd address read returned data");
  a_rsvd_bit_zero: assert property (rd_req ##0 (HADDR == BS_ADDR) |=> rd_answer ##0 !HRDATA[3])
    else $error("reserved burst bit read as one");
  a_resp_always_okay: assert property (HRESP == 1'b0)
    else $error("error response driven");

  // ---------------------------------------------------------------
  // descriptor chains
  // ---------------------------------------------------------------
  a_rx_unlinked_zero: assert property (!RX_LINKING_ON [*2] |-> RX_CHAIN_LEFT == 8'h0)
    else $error("rx chain counts while unlinked");
  a_tx_unlinked_zero: assert property (!TX_LINKING_ON [*2] |-> TX_CHAIN_LEFT == 8'h0)
    else $error("tx chain counts while unlinked");
  a_rx_chain_step: assert property (RX_LINKING_ON && RX_DESC_DONE && !RX_CHAIN_START &&
    RX_CHAIN_LEFT != 8'h0 |=> RX_CHAIN_LEFT == $past(RX_CHAIN_LEFT) - 8'h1)
    else $error("rx chain did not step down by one");
  a_tx_chain_end: assert property (TX_LINKING_ON && TX_DESC_DONE && !TX_CHAIN_START &&
    TX_CHAIN_LEFT == 8'h1 |=> TX_CHAIN_END && TX_CHAIN_LEFT == 8'h0)
    else $error("tx chain end not flagged");

  // ---------------------------------------------------------------
  // rx bursts
  // ---------------------------------------------------------------
  a_valid_in_burst: assert property (DMA_VALID |-> DMA_BURST_REQ)
    else $error("data offered outside a burst");
  a_burst_len_range: assert property ($rose(DMA_BURST_REQ) |-> DMA_BURST_LEN inside {[1:128]})
    else $error("burst length out of range");
endmodule

bind udbl_top udbl_top_assertions udbl_top_assertions_inst (.CLK(CLK), .SYS_RST(SYS_RST),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_LINKING_ON(RX_LINKING_ON),
  .TX_LINKING_ON(TX_LINKING_ON), .RX_CHAIN_START(RX_CHAIN_START),
  .TX_CHAIN_START(TX_CHAIN_START), .RX_DESC_DONE(RX_DESC_DONE), .TX_DESC_DONE(TX_DESC_DONE),
  .RX_CHAIN_LEFT(RX_CHAIN_LEFT), .TX_CHAIN_LEFT(TX_CHAIN_LEFT), .TX_CHAIN_END(TX_CHAIN_END),
  .DMA_VALID(DMA_VALID), .DMA_BURST_REQ(DMA_BURST_REQ), .DMA_BURST_LEN(DMA_BURST_LEN));

// ### testbench/udbl_dma_sink.sv
// dma-side sink that takes the rx stream word by word
`timescale 1ns/10ps

module udbl_dma_sink (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        dma_valid,
  input  wire logic [31:0] dma_data,
  input  wire logic        hold,
  input  wire logic        slow,
  output logic             dma_ready,
  output logic [15:0]      got_cnt,
  output logic [31:0]      got_last
);
  logic phase;

  // slow mode stalls every other cycle to keep the fifo under back-pressure
  assign dma_ready = !hold && (!slow || phase);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= 1'b0;
      got_cnt <= 16'h0;
      got_last <= 32'h0;
    end
    else
    begin
      phase <= !phase;
      if (dma_valid && dma_ready)
      begin
        got_cnt <= got_cnt + 16'h1;
        got_last <= dma_data;
      end
    end
  end
endmodule

// ### testbench/udbl_top_tb.sv
// self-checking bench for the dma/buffer-table block
`timescale 1ns/10ps
`include "udbl_defs.vh"

module udbl_top_tb;
  localparam logic [31:0] BS = `UDBL_REG_BASE + 32'h860;
  localparam logic [31:0] CL = `UDBL_REG_BASE + 32'h864;
  localparam logic [31:0] TB = `UDBL_REG_BASE + 32'h850;
  localparam logic [31:0] PM = `UDBL_PMEM_BASE;
  logic        CLK, SYS_RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
  logic        RX_LINKING_ON, TX_LINKING_ON, RX_CHAIN_START, TX_CHAIN_START;
  logic        RX_DESC_DONE, TX_DESC_DONE, RX_CHAIN_END, TX_CHAIN_END, RX_XFER_LOAD;
  logic        RX_DATA_VALID, RX_DATA_READY, DMA_BURST_REQ, DMA_LAST_BURST, DMA_VALID;
  logic        DMA_READY, hold, slow;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [3:0]  EP_INDEX;
  logic [7:0]  RX_CHAIN_LEFT, TX_CHAIN_LEFT, DMA_BURST_LEN;
  logic [15:0] RX_BUF_POINTER, TX_BUF_POINTER, RX_XFER_COUNT, got_cnt, base;
  logic [31:0] HADDR, HWDATA, HRDATA, RX_DATA, DMA_DATA, got_last, rd;
  int          fail_count = 0;
  int          checks = 0;

  // single slave on the bus: bus ready follows the slave
  assign HREADY = HREADYOUT;

  udbl_top udbl_top_inst (.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EP_INDEX(EP_INDEX),
    .RX_BUF_POINTER(RX_BUF_POINTER), .TX_BUF_POINTER(TX_BUF_POINTER),
    .RX_LINKING_ON(RX_LINKING_ON), .TX_LINKING_ON(TX_LINKING_ON),
    .RX_CHAIN_START(RX_CHAIN_START), .TX_CHAIN_START(TX_CHAIN_START),
    .RX_DESC_DONE(RX_DESC_DONE), .TX_DESC_DONE(TX_DESC_DONE), .RX_CHAIN_LEFT(RX_CHAIN_LEFT),
    .TX_CHAIN_LEFT(TX_CHAIN_LEFT), .RX_CHAIN_END(RX_CHAIN_END), .TX_CHAIN_END(TX_CHAIN_END),
    .RX_XFER_LOAD(RX_XFER_LOAD), .RX_XFER_COUNT(RX_XFER_COUNT), .RX_DATA_VALID(RX_DATA_VALID),
    .RX_DATA_READY(RX_DATA_READY), .RX_DATA(RX_DATA), .DMA_BURST_REQ(DMA_BURST_REQ),
    .DMA_BURST_LEN(DMA_BURST_LEN), .DMA_LAST_BURST(DMA_LAST_BURST), .DMA_VALID(DMA_VALID),
    .DMA_READY(DMA_READY), .DMA_DATA(DMA_DATA));

  udbl_dma_sink udbl_dma_sink_inst (.clk(CLK), .rst(SYS_RST), .dma_valid(DMA_VALID),
    .dma_data(DMA_DATA), .hold(hold), .slow(slow), .dma_ready(DMA_READY),
    .got_cnt(got_cnt), .got_last(got_last));

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(inout int n);
    @(posedge CLK);
    n++;
    if (n > 400)
    begin
      fail_count++;
      $display("wait limit reached at %0t", $time);
      print_verdict;
    end
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d);
    int n;
    n = 0;
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    HSIZE <= s;
    @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    tick(n);
    while (!HREADYOUT) tick(n);
    rd = HRDATA;
  endtask

  task push(input logic [31:0] v);
    int n;
    n = 0;
    RX_DATA_VALID <= 1'b1;
    RX_DATA <= v;
    tick(n);
    while (!RX_DATA_READY) tick(n);
  endtask

  task pulse(input logic [3:0] m);
    {RX_CHAIN_START, TX_CHAIN_START, RX_DESC_DONE, TX_DESC_DONE} <= m;
    @(posedge CLK);
    {RX_CHAIN_START, TX_CHAIN_START, RX_DESC_DONE, TX_DESC_DONE} <= 4'h0;
    @(posedge CLK);
  endtask

  task load_xfer(input logic [15:0] cnt);
    base = got_cnt;
    RX_XFER_LOAD <= 1'b1;
    RX_XFER_COUNT <= cnt;
    @(posedge CLK);
    RX_XFER_LOAD <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    ahb(0, CL, 3'h2, 0);
    chk(rd, 32'h0);
    ahb(0, BS, 3'h2, 0);
    chk(rd, 32'h0100);
    ahb(1, BS, 3'h2, 32'hffff);
    ahb(0, BS, 3'h2, 0);
    chk(rd, 32'hff77);
    ahb(1, BS + 32'h1, 3'h0, 32'h0000_0000);
    ahb(0, BS + 32'h1, 3'h0, 0);
    chk(rd, 32'h0);
    ahb(0, BS, 3'h2, 0);
    chk(rd, 32'hff77);
    ahb(0, `UDBL_REG_BASE + 32'h700, 3'h2, 0);
    chk(rd, 32'h0);
    $display("test registers done");
  endtask

  task t_chain;
    ahb(1, CL, 3'h2, 32'h0503);
    ahb(0, CL, 3'h2, 0);
    chk(rd, 32'h0503);
    RX_LINKING_ON <= 1'b1;
    TX_LINKING_ON <= 1'b1;
    pulse(4'b1100);
    chk({RX_CHAIN_LEFT, TX_CHAIN_LEFT}, 32'h0503);
    pulse(4'b0011);
    repeat (2) pulse(4'b0001);
    chk({RX_CHAIN_LEFT, TX_CHAIN_LEFT, RX_CHAIN_END, TX_CHAIN_END}, {8'h4, 8'h0, 2'b01});
    RX_LINKING_ON <= 1'b0;
    pulse(4'b0010);
    chk(RX_CHAIN_LEFT, 32'h0);
    TX_LINKING_ON <= 1'b0;
    $display("test chains done");
  endtask

  task t_table;
    ahb(1, TB, 3'h2, 32'h10);
    ahb(1, PM + 32'h10, 3'h2, 32'h0008_000c);
    ahb(1, PM + 32'h20, 3'h2, 32'h0040_0080);
    ahb(1, PM + 32'h22, 3'h1, 32'h0100_0000);
    EP_INDEX <= 4'h2;
    repeat (2) @(posedge CLK);
    chk(RX_BUF_POINTER, 32'h0100);
    chk(TX_BUF_POINTER, 32'h0080);
    EP_INDEX <= 4'h0;
    repeat (2) @(posedge CLK);
    chk({RX_BUF_POINTER, TX_BUF_POINTER}, 32'h0008_000c);
    ahb(0, PM + 32'h20, 3'h2, 0);
    chk(rd, 32'h0100_0080);
    $display("test table done");
  endtask

  task t_codes;
    int n;
    for (int c = 0; c < 8; c++)
    begin
      ahb(1, BS, 3'h2, {29'h0, c[2:0]});
      load_xfer(16'h3);
      for (int i = 0; i < 3; i++) push(32'h100 * c + i);
      RX_DATA_VALID <= 1'b0;
      n = 0;
      while (!DMA_BURST_REQ) tick(n);
      chk({DMA_LAST_BURST, DMA_BURST_LEN}, (c == 0 || c == 7) ? 9'h001 : 9'h103);
      hold <= 1'b0;
      while (got_cnt != base + 16'h3) tick(n);
      chk(got_last, 32'h100 * c + 2);
      hold <= 1'b1;
    end
    $display("test burst codes done");
  endtask

  task t_fifo;
    int n;
    ahb(1, BS, 3'h2, 32'h3);
    load_xfer(16'h10);
    for (int i = 0; i < 8; i++) push(32'ha00 + i);
    RX_DATA_VALID <= 1'b0;
    @(posedge CLK);
    chk(RX_DATA_READY, 32'h0);
    n = 0;
    while (!DMA_BURST_REQ) tick(n);
    chk({DMA_LAST_BURST, DMA_BURST_LEN}, 9'h110);
    slow <= 1'b1;
    hold <= 1'b0;
    for (int i = 8; i < 16; i++) push(32'ha00 + i);
    RX_DATA_VALID <= 1'b0;
    while (got_cnt != base + 16'h10) tick(n);
    chk({DMA_VALID, got_last}, 33'h0_0000_0a0f);
    $display("test fifo done");
  endtask

  initial
  begin
    {SYS_RST, HSEL, HWRITE, RX_LINKING_ON, TX_LINKING_ON, RX_XFER_LOAD} = 6'h20;
    {RX_CHAIN_START, TX_CHAIN_START, RX_DESC_DONE, TX_DESC_DONE, RX_DATA_VALID} = 5'h0;
    {HTRANS, HSIZE, EP_INDEX, RX_XFER_COUNT, HADDR, HWDATA, RX_DATA} = 0;
    hold = 1'b1;
    slow = 1'b0;
    repeat (20) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    t_regs;
    t_chain;
    t_table;
    t_codes;
    t_fifo;
    print_verdict;
  end
endmodule
